//--- hdl/ipd_consts.svh
`ifndef IPD_CONSTS_SVH
`define IPD_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses on the plain register port
// ----------------------------------------------------------------
`define IPD_ADDR_W 4
`define IPD_ADDR_VREG 4'h0
`define IPD_ADDR_DOZE 4'h1

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define IPD_VREG_RST 2'h1
`define IPD_VREG_MASK 8'h03
`define IPD_DOZE_MASK 8'hF7
`define IPD_RDATA_ZERO 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IPD_BIT_IDLE 7
`define IPD_BIT_DOZE_ACTIVE 6
`define IPD_BIT_ROI 5
`define IPD_BIT_DOE 4
`define IPD_RATIO_HI 2
`define IPD_RATIO_LO 0
`define IPD_PM_HI 1
`define IPD_PM_LO 0

// ----------------------------------------------------------------
// Doze rate counter
// ----------------------------------------------------------------
`define IPD_CNT_W 8
`define IPD_CNT_ZERO 8'h00
`define IPD_CNT_ONE 8'h01
`define IPD_CNT_ALL 8'hFF
`define IPD_RATIO_MAX 3'h7

`endif

//--- hdl/ipd_pkg.sv
package ipd_pkg;

  // ----------------------------------------------------------------
  // Power state of the core
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IPD_RUN = 2'b00,
    IPD_IDLE = 2'b01,
    IPD_SLEEP = 2'b10
  } ipd_state_e;

  // CPU sequencing events, all one-cycle pulses from the core
  typedef struct packed {
    logic sleep_instr;
    logic isr_entry;
    logic return_from_irq_instr;
  } ipd_cpu_evt_s;

  // Clock gate enables toward the clock tree
  typedef struct packed {
    logic cpu;
    logic prog_mem;
    logic sysosc_periph;
    logic intosc_periph;
    logic clock_output_function;
  } ipd_clk_en_s;

endpackage : ipd_pkg

//--- hdl/ipd_doze_gate.sv
`timescale 1ns/1ps
`include "ipd_consts.svh"

module ipd_doze_gate (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Ratio select and pass strobe
  input wire logic [2:0] ratio,
  output logic pass
);
  import ipd_pkg::*;

  logic [`IPD_CNT_W-1:0] cnt_ff;
  logic [`IPD_CNT_W-1:0] mask;

  // Free-running so a ratio change never waits for a reload
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= `IPD_CNT_ZERO;
    end else begin
      cnt_ff <= cnt_ff + `IPD_CNT_ONE;
    end
  end

  // Mask of 2^(ratio+1)-1 gives one pass per 2..256 cycles
  assign mask = `IPD_CNT_ALL >> (`IPD_RATIO_MAX - ratio);
  assign pass = ((cnt_ff & mask) == `IPD_CNT_ZERO);

endmodule : ipd_doze_gate

//--- hdl/ipd_top.sv
// Summary of operation
// - Sleep instruction picks Sleep or Idle
// - Idle stops CPU and program memory
// - System peripherals stop only in Sleep
// - Clock output keeps toggling during Idle
// - Any enabled interrupt ends Idle, select kept
// - Idle-ending interrupt with recover restores speed
// - Watchdog wakes Idle, no reset, doze kept
// - Two-bit field picks Sleep regulator state
// - Doze active gates CPU to ratio
// - Recover clears doze on service entry
// - Doze-on-return sets doze on return
// - Ratio field gives 1:2 up to 1:256
// - Debugger forces full speed, bit kept
// - Unimplemented bits read as zero
// - Idle select survives non-power resets only
// - Without recover, service runs at doze rate
// - Wake needs source enable, not global
`timescale 1ns/1ps
`include "ipd_consts.svh"

module ipd_top (
  // Clock and resets
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic POR_BOR_N,
  // Register port
  input wire logic [`IPD_ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Core events and interrupt sources
  input wire ipd_pkg::ipd_cpu_evt_s CPU_EVT,
  input wire logic [7:0] IRQ_FLAGS,
  input wire logic [7:0] IRQ_ENABLES,
  input wire logic ICD_ACTIVE,
  input wire logic CLOCK_OUTPUT_FUNCTION_CFG_N,
  // Watchdog time-out from the slow oscillator domain
  input wire logic WDT_TIMEOUT,
  // Clock gating and power outputs
  output ipd_pkg::ipd_clk_en_s CLK_EN,
  output logic [1:0] REGULATOR_POWER_MODE,
  output logic IN_IDLE,
  output logic IN_SLEEP,
  output logic WDT_RST_REQ
);
  import ipd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ipd_state_e state_ff;
  ipd_state_e nxt_state;
  logic [1:0] regulator_power_mode_ff;
  logic idle_select_ff;
  logic doze_active_ff;
  logic recover_on_irq_ff;
  logic doze_on_return_ff;
  logic [2:0] ratio_ff;
  logic wdt_meta_ff;
  logic wdt_sync_ff;
  logic wdt_prev_ff;
  logic [7:0] rdata_ff;
  ipd_clk_en_s clk_en_ff;
  ipd_clk_en_s nxt_clk_en;
  logic in_idle_ff;
  logic in_sleep_ff;
  logic wdt_rst_req_ff;
  logic irq_wake;
  logic wdt_evt;
  logic wr_vreg;
  logic wr_doze;
  logic doze_hw_clr;
  logic doze_hw_set;
  logic doze_pass;
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Wake needs a flag with its own enable; global enable is not looked at
  assign irq_wake = |(IRQ_FLAGS & IRQ_ENABLES);
  assign wdt_evt = wdt_sync_ff & ~wdt_prev_ff;
  assign wr_vreg = REG_WR && (REG_ADDR == `IPD_ADDR_VREG);
  assign wr_doze = REG_WR && (REG_ADDR == `IPD_ADDR_DOZE);

  // Watchdog level crosses from its own oscillator in two flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wdt_meta_ff <= 1'b0;
      wdt_sync_ff <= 1'b0;
      wdt_prev_ff <= 1'b0;
    end else begin
      wdt_meta_ff <= WDT_TIMEOUT;
      wdt_sync_ff <= wdt_meta_ff;
      wdt_prev_ff <= wdt_sync_ff;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  // A pending enabled interrupt turns the sleep instruction into a no-op
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IPD_RUN: begin
        if (CPU_EVT.sleep_instr && !irq_wake) begin
          nxt_state = idle_select_ff ? IPD_IDLE : IPD_SLEEP;
        end
      end
      IPD_IDLE: begin
        if (irq_wake || wdt_evt) begin
          nxt_state = IPD_RUN;
        end
      end
      IPD_SLEEP: begin
        if (irq_wake || wdt_evt) begin
          nxt_state = IPD_RUN;
        end
      end
      default: begin
        nxt_state = IPD_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= IPD_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Idle select sits on the power-on reset only, so it outlives others
  always_ff @(posedge CLK or negedge POR_BOR_N) begin
    if (!POR_BOR_N) begin
      idle_select_ff <= 1'b0;
    end else if (wr_doze) begin
      idle_select_ff <= REG_WDATA[`IPD_BIT_IDLE];
    end
  end

  // Remaining doze fields clear on every reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      recover_on_irq_ff <= 1'b0;
      doze_on_return_ff <= 1'b0;
      ratio_ff <= 3'h0;
    end else if (wr_doze) begin
      recover_on_irq_ff <= REG_WDATA[`IPD_BIT_ROI];
      doze_on_return_ff <= REG_WDATA[`IPD_BIT_DOE];
      ratio_ff <= REG_WDATA[`IPD_RATIO_HI:`IPD_RATIO_LO];
    end
  end

  // Regulator mode for Sleep, normal power after reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      regulator_power_mode_ff <= `IPD_VREG_RST;
    end else if (wr_vreg) begin
      regulator_power_mode_ff <= REG_WDATA[`IPD_PM_HI:`IPD_PM_LO];
    end
  end

  // Hardware doze changes; a watchdog wake never touches the bit
  assign doze_hw_clr = recover_on_irq_ff &&
                       (CPU_EVT.isr_entry ||
                        (state_ff == IPD_IDLE && irq_wake));
  assign doze_hw_set = doze_on_return_ff && CPU_EVT.return_from_irq_instr;

  // Hardware wins over a software write in the same cycle, set over clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      doze_active_ff <= 1'b0;
    end else if (doze_hw_set) begin
      doze_active_ff <= 1'b1;
    end else if (doze_hw_clr) begin
      doze_active_ff <= 1'b0;
    end else if (wr_doze) begin
      doze_active_ff <= REG_WDATA[`IPD_BIT_DOZE_ACTIVE];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unused bits are tied low; unmapped addresses read zero
  always_comb begin
    rd_mux = `IPD_RDATA_ZERO;
    case (REG_ADDR)
      `IPD_ADDR_VREG: begin
        rd_mux[`IPD_PM_HI:`IPD_PM_LO] = regulator_power_mode_ff;
      end
      `IPD_ADDR_DOZE: begin
        rd_mux[`IPD_BIT_IDLE] = idle_select_ff;
        rd_mux[`IPD_BIT_DOZE_ACTIVE] = doze_active_ff;
        rd_mux[`IPD_BIT_ROI] = recover_on_irq_ff;
        rd_mux[`IPD_BIT_DOE] = doze_on_return_ff;
        rd_mux[`IPD_RATIO_HI:`IPD_RATIO_LO] = ratio_ff;
      end
      default: begin
        rd_mux = `IPD_RDATA_ZERO;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= `IPD_RDATA_ZERO;
    end else if (REG_RD) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= `IPD_RDATA_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Doze rate gate
  // ----------------------------------------------------------------
  ipd_doze_gate ipd_doze_gate_i (
    .clk(CLK),
    .arst_n(ARST_N),
    .ratio(ratio_ff),
    .pass(doze_pass)
  );

  // Clock enables; debug overrides doze without touching the stored bit
  always_comb begin
    nxt_clk_en.cpu = (state_ff == IPD_RUN) &&
                     (ICD_ACTIVE || !doze_active_ff || doze_pass);
    nxt_clk_en.prog_mem = (state_ff == IPD_RUN);
    nxt_clk_en.sysosc_periph = (state_ff != IPD_SLEEP);
    nxt_clk_en.intosc_periph = 1'b1;
    nxt_clk_en.clock_output_function = !CLOCK_OUTPUT_FUNCTION_CFG_N && (state_ff != IPD_SLEEP);
  end

  // Service routines without recover simply inherit the doze gating
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_en_ff <= '0;
    end else begin
      clk_en_ff <= nxt_clk_en;
    end
  end

  // Status outputs; watchdog reset is blocked while powered down
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_idle_ff <= 1'b0;
      in_sleep_ff <= 1'b0;
      wdt_rst_req_ff <= 1'b0;
    end else begin
      in_idle_ff <= (state_ff == IPD_IDLE);
      in_sleep_ff <= (state_ff == IPD_SLEEP);
      wdt_rst_req_ff <= wdt_evt && (state_ff == IPD_RUN);
    end
  end

  assign REG_RDATA = rdata_ff;
  assign CLK_EN = clk_en_ff;
  assign REGULATOR_POWER_MODE = regulator_power_mode_ff;
  assign IN_IDLE = in_idle_ff;
  assign IN_SLEEP = in_sleep_ff;
  assign WDT_RST_REQ = wdt_rst_req_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_sleep_req;
    state_ff == IPD_RUN && CPU_EVT.sleep_instr && !irq_wake;
  endsequence

  sequence s_idle_irq;
    state_ff == IPD_IDLE && irq_wake && !wr_doze;
  endsequence

  sequence s_idle_wdt;
    state_ff == IPD_IDLE && wdt_evt && !irq_wake && !wr_doze;
  endsequence

  chk_sleep_to_idle: assert property (s_sleep_req and idle_select_ff |=>
    state_ff == IPD_IDLE ##1 IN_IDLE)
    else $error("sleep with idle select did not enter idle");

  chk_sleep_to_full: assert property (s_sleep_req and !idle_select_ff |=>
    state_ff == IPD_SLEEP ##1 IN_SLEEP)
    else $error("sleep without idle select did not enter sleep");

  chk_idle_gating: assert property (state_ff == IPD_IDLE |=>
    !CLK_EN.cpu && !CLK_EN.prog_mem && CLK_EN.sysosc_periph)
    else $error("idle gating wrong");

  chk_sleep_periph: assert property (state_ff == IPD_SLEEP |=>
    !CLK_EN.sysosc_periph && CLK_EN.intosc_periph)
    else $error("sleep peripheral gating wrong");

  chk_clock_output_function_idle: assert property (state_ff == IPD_IDLE && !CLOCK_OUTPUT_FUNCTION_CFG_N |=>
    CLK_EN.clock_output_function)
    else $error("clock output stopped in idle");

  chk_irq_ends_idle: assert property (s_idle_irq |=>
    state_ff == IPD_RUN && $stable(idle_select_ff))
    else $error("interrupt did not end idle cleanly");

  chk_roi_idle_exit: assert property (s_idle_irq and recover_on_irq_ff and !doze_hw_set |=>
    !doze_active_ff)
    else $error("recover did not clear doze on idle exit");

  chk_wdt_idle_wake: assert property (s_idle_wdt and !doze_hw_set and !doze_hw_clr |=>
    state_ff == IPD_RUN && $stable(doze_active_ff) ##0 !WDT_RST_REQ)
    else $error("watchdog in idle misbehaved");

  chk_vreg_write: assert property (wr_vreg |=>
    REGULATOR_POWER_MODE == $past(REG_WDATA[`IPD_PM_HI:`IPD_PM_LO]))
    else $error("regulator mode not updated");

  chk_doze_skip: assert property (state_ff == IPD_RUN && doze_active_ff && !ICD_ACTIVE &&
    !doze_pass |=> !CLK_EN.cpu)
    else $error("cpu enabled off the doze slot");

  chk_full_speed: assert property (state_ff == IPD_RUN && (!doze_active_ff || ICD_ACTIVE)
    |=> CLK_EN.cpu)
    else $error("cpu not at full speed");

  chk_roi_entry: assert property (CPU_EVT.isr_entry && recover_on_irq_ff && !doze_hw_set
    |=> !doze_active_ff)
    else $error("service entry did not clear doze");

  chk_doe_return: assert property (doze_hw_set |=> doze_active_ff)
    else $error("return did not set doze");

  chk_reserved_zero: assert property (REG_RD |=>
    ($past(REG_ADDR) != `IPD_ADDR_VREG || (REG_RDATA & ~`IPD_VREG_MASK) == `IPD_RDATA_ZERO) &&
    ($past(REG_ADDR) != `IPD_ADDR_DOZE || (REG_RDATA & ~`IPD_DOZE_MASK) == `IPD_RDATA_ZERO))
    else $error("unimplemented bits read nonzero");

endmodule : ipd_top

//--- bench/test_idle_doze_power_control.sv
`timescale 1ns/1ps
`include "ipd_consts.svh"

// Compare and count; case equality so unknowns never match
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module test_idle_doze_power_control;
  import ipd_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [3:0] VR = `IPD_ADDR_VREG;
  localparam logic [3:0] DZ = `IPD_ADDR_DOZE;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic POR_BOR_N = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  ipd_cpu_evt_s CPU_EVT = '0;
  logic [7:0] IRQ_FLAGS = 8'h00;
  logic [7:0] IRQ_ENABLES = 8'h00;
  logic ICD_ACTIVE = 1'b0;
  logic CLOCK_OUTPUT_FUNCTION_CFG_N = 1'b0;
  logic WDT_TIMEOUT = 1'b0;
  ipd_clk_en_s CLK_EN;
  logic [1:0] REGULATOR_POWER_MODE;
  logic IN_IDLE;
  logic IN_SLEEP;
  logic WDT_RST_REQ;
  int n_mismatch = 0;
  int checked = 0;
  int wdt_cnt = 0;
  int cpu_cnt = 0;

  ipd_top ipd_top_i (
    .CLK(CLK), .ARST_N(ARST_N), .POR_BOR_N(POR_BOR_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_EVT(CPU_EVT),
    .IRQ_FLAGS(IRQ_FLAGS), .IRQ_ENABLES(IRQ_ENABLES), .ICD_ACTIVE(ICD_ACTIVE),
    .CLOCK_OUTPUT_FUNCTION_CFG_N(CLOCK_OUTPUT_FUNCTION_CFG_N), .WDT_TIMEOUT(WDT_TIMEOUT), .CLK_EN(CLK_EN),
    .REGULATOR_POWER_MODE(REGULATOR_POWER_MODE), .IN_IDLE(IN_IDLE),
    .IN_SLEEP(IN_SLEEP), .WDT_RST_REQ(WDT_RST_REQ)
  );

  // 40 MHz clock
  always #12.5 CLK = ~CLK;

  // Count watchdog reset requests; must stay silent while parked
  always @(posedge CLK) begin
    if (ARST_N === 1'b1 && WDT_RST_REQ === 1'b1) wdt_cnt++;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    `CHK(REG_RDATA, e)
  endtask : rdc

  task automatic evt(input logic [2:0] v);
    @(posedge CLK);
    CPU_EVT <= ipd_cpu_evt_s'(v);
    @(posedge CLK);
    CPU_EVT <= '0;
  endtask : evt

  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step

  task automatic irq(input logic [7:0] f);
    @(posedge CLK);
    IRQ_FLAGS <= f;
  endtask : irq

  // Counts CPU enables over a window that spans whole doze periods
  task automatic count_cpu(input int n);
    cpu_cnt = 0;
    repeat (n) begin
      @(posedge CLK);
      #1;
      if (CLK_EN.cpu === 1'b1) cpu_cnt++;
    end
  endtask : count_cpu

  task automatic do_reset(input logic por);
    @(posedge CLK);
    ARST_N <= 1'b0;
    POR_BOR_N <= ~por;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    POR_BOR_N <= 1'b1;
  endtask : do_reset

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    POR_BOR_N <= 1'b1;
    rdc(VR, 8'h01);
    `CHK(REGULATOR_POWER_MODE, 2'h1)
    rdc(DZ, 8'h00);
    wr(VR, 8'hFF);
    rdc(VR, 8'h03);
    wr(DZ, 8'hFF);
    rdc(DZ, 8'hF7);
    wr(4'h5, 8'hFF);
    rdc(4'h5, 8'h00);
    // Every regulator code, reserved bits written as ones
    for (int i = 0; i < 4; i++) begin
      wr(VR, {6'h3F, 2'(i)});
      rdc(VR, {6'h00, 2'(i)});
      `CHK(REGULATOR_POWER_MODE, 2'(i))
    end
    // Idle with a flag whose enable is off: must not wake
    irq(8'h01);
    wr(DZ, 8'h80);
    evt(3'b100);
    step(3);
    `CHK(IN_IDLE, 1'b1)
    `CHK(CLK_EN, 5'b00111)
    step(4);
    `CHK(IN_IDLE, 1'b1)
    @(posedge CLK);
    IRQ_ENABLES <= 8'h01;
    step(3);
    `CHK(IN_IDLE, 1'b0)
    rdc(DZ, 8'h80);
    irq(8'h00);
    // Full sleep stops system-clock peripherals only
    wr(DZ, 8'h00);
    evt(3'b100);
    step(3);
    `CHK(IN_SLEEP, 1'b1)
    `CHK({CLK_EN.cpu, CLK_EN.sysosc_periph, CLK_EN.intosc_periph}, 3'b001)
    irq(8'h01);
    step(3);
    `CHK(IN_SLEEP, 1'b0)
    irq(8'h00);
    // Recover on interrupt while idle and dozing
    wr(DZ, 8'hE0);
    evt(3'b100);
    step(3);
    irq(8'h01);
    step(3);
    rdc(DZ, 8'hA0);
    irq(8'h00);
    // Watchdog wakes idle without reset and leaves doze alone
    wr(DZ, 8'hE0);
    evt(3'b100);
    step(3);
    `CHK(IN_IDLE, 1'b1)
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b1;
    step(8);
    `CHK(IN_IDLE, 1'b0)
    `CHK(wdt_cnt, 0)
    rdc(DZ, 8'hE0);
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    step(4);
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b1;
    step(8);
    `CHK(wdt_cnt, 1)
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    // Service entry and return with each control bit
    wr(DZ, 8'h60);
    evt(3'b010);
    rdc(DZ, 8'h20);
    wr(DZ, 8'h40);
    evt(3'b010);
    rdc(DZ, 8'h40);
    count_cpu(64);
    `CHK(cpu_cnt, 32)
    wr(DZ, 8'h10);
    evt(3'b001);
    rdc(DZ, 8'h50);
    wr(DZ, 8'h00);
    evt(3'b001);
    rdc(DZ, 8'h00);
    // Every doze ratio; 512 cycles holds whole periods of each
    for (int r = 0; r < 8; r++) begin
      wr(DZ, {5'b01000, 3'(r)});
      step(8);
      count_cpu(512);
      `CHK(cpu_cnt, 512 >> (r + 1))
    end
    wr(DZ, 8'h07);
    count_cpu(64);
    `CHK(cpu_cnt, 64)
    // Debugger overrides doze but keeps the stored bit
    wr(DZ, 8'h47);
    @(posedge CLK);
    ICD_ACTIVE <= 1'b1;
    step(3);
    count_cpu(64);
    `CHK(cpu_cnt, 64)
    rdc(DZ, 8'h47);
    @(posedge CLK);
    ICD_ACTIVE <= 1'b0;
    CLOCK_OUTPUT_FUNCTION_CFG_N <= 1'b1;
    step(3);
    `CHK(CLK_EN.clock_output_function, 1'b0)
    // Plain reset keeps idle select, power-on reset clears it
    wr(DZ, 8'hB5);
    wr(VR, 8'h00);
    do_reset(1'b0);
    rdc(DZ, 8'h80);
    rdc(VR, 8'h01);
    do_reset(1'b1);
    rdc(DZ, 8'h00);
    results();
  end

  // Hang guard: the sequence needs about 4600 cycles
  initial begin
    #(25 * 20000);
    n_mismatch++;
    results();
  end

endmodule : test_idle_doze_power_control
